// ### rtl/cpu_status_pkg.sv
// Purpose: Constants and carriers for the status word and second operand registers
// Assumes: 8-bit direct special function register space
// Notes:   Both registers sit on every register page
package cpu_status_pkg;

   // ----------------------------------------------------------------
   // Register addresses and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_WORD_ADDR   = 8'hD0;
   localparam logic [7:0] SECOND_OPND_ADDR   = 8'hF0;
   localparam logic [7:0] STATUS_WORD_RESET  = 8'h00;
   localparam logic [7:0] SECOND_OPND_RESET  = 8'h00;

   // ----------------------------------------------------------------
   // Status word field positions
   // ----------------------------------------------------------------
   localparam int CARRY_BIT    = 7;
   localparam int NIBBLE_BIT   = 6;
   localparam int USER0_BIT    = 5;
   localparam int BANK_HI_BIT  = 4;
   localparam int BANK_LO_BIT  = 3;
   localparam int OVERFLOW_BIT = 2;
   localparam int USER1_BIT    = 1;
   localparam int PARITY_BIT   = 0;
   localparam logic [4:0] BANK_SPAN = 5'h08;

   // ----------------------------------------------------------------
   // Arithmetic operation codes from the core
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_ADD  = 3'b001,
      OP_ADDC = 3'b010,
      OP_SUBB = 3'b011,
      OP_MUL  = 3'b100,
      OP_DIV  = 3'b101
   } arith_op_e;

   // Register access from the core
   typedef struct packed {
      logic       byteWr;
      logic       bitWr;
      logic [7:0] addr;
      logic [2:0] bitSel;
      logic [7:0] wrData;
      logic       bitVal;
   } sfr_req_s;

   // Arithmetic request from the core
   typedef struct packed {
      arith_op_e  op;
      logic [7:0] opA;
      logic [7:0] opB;
   } arith_req_s;

endpackage

// ### rtl/cpu_status_and_b_register.sv
// Purpose: Status word and second operand registers of the CPU core
// Assumes: Core supplies accumulator value, arithmetic request and SFR writes
// Notes:   Arithmetic flag update wins over a software write in the same cycle
`timescale 1ns/10ps

module cpu_status_and_b_register
   import cpu_status_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire sfr_req_s   sfrReq,
   input  wire arith_req_s arithReq,
   input  wire logic [7:0] accValue,
   input  wire logic [7:0] mulHigh,
   input  wire logic [7:0] mulLow,
   input  wire logic [7:0] divQuot,
   input  wire logic [7:0] divRem,
   output logic      [7:0] statusWord,
   output logic      [7:0] secondOperand,
   output logic      [7:0] rdData,
   output logic            carryOut,
   output logic      [4:0] bankBase
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic [2:0] sel,
                                            input logic v);
      logic [7:0] res;
      res      = cur;
      res[sel] = v;
      return res;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      return a == target;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] statusStore_r;
   logic [7:0] statusStore_nxt;
   logic [7:0] second_r;
   logic [7:0] second_nxt;
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic       parity;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic       cin;
   logic       ovAdd;
   logic       ovSub;

   assign parity = ^accValue;
   assign cin    = (arithReq.op == OP_NONE || arithReq.op == OP_ADD) ? 1'b0
                   : statusStore_r[CARRY_BIT];

   // ----------------------------------------------------------------
   // Arithmetic flag terms
   // ----------------------------------------------------------------
   always_comb begin
      sum9  = 9'h000;
      sum5  = 5'h00;
      ovAdd = 1'b0;
      ovSub = 1'b0;
      if (arithReq.op == OP_SUBB) begin
         sum9  = {1'b0, arithReq.opA} - {1'b0, arithReq.opB} - {8'h00, cin};
         sum5  = {1'b0, arithReq.opA[3:0]} - {1'b0, arithReq.opB[3:0]} - {4'h0, cin};
         ovSub = (arithReq.opA[7] != arithReq.opB[7]) && (sum9[7] != arithReq.opA[7]);
      end else begin
         sum9  = {1'b0, arithReq.opA} + {1'b0, arithReq.opB} + {8'h00, cin};
         sum5  = {1'b0, arithReq.opA[3:0]} + {1'b0, arithReq.opB[3:0]} + {4'h0, cin};
         ovAdd = (arithReq.opA[7] == arithReq.opB[7]) && (sum9[7] != arithReq.opA[7]);
      end
   end

   // ----------------------------------------------------------------
   // Next register values
   // ----------------------------------------------------------------
   always_comb begin
      statusStore_nxt = statusStore_r;
      second_nxt      = second_r;
      if (sfrReq.byteWr && hit(sfrReq.addr, STATUS_WORD_ADDR)) begin
         statusStore_nxt = sfrReq.wrData;
      end
      if (sfrReq.bitWr && hit(sfrReq.addr, STATUS_WORD_ADDR)) begin
         statusStore_nxt = merge_bit(statusStore_r, sfrReq.bitSel, sfrReq.bitVal);
      end
      if (sfrReq.byteWr && hit(sfrReq.addr, SECOND_OPND_ADDR)) begin
         second_nxt = sfrReq.wrData;
      end
      if (sfrReq.bitWr && hit(sfrReq.addr, SECOND_OPND_ADDR)) begin
         second_nxt = merge_bit(second_r, sfrReq.bitSel, sfrReq.bitVal);
      end
      case (arithReq.op)
         OP_ADD, OP_ADDC: begin
            statusStore_nxt[CARRY_BIT]    = sum9[8];
            statusStore_nxt[NIBBLE_BIT]   = sum5[4];
            statusStore_nxt[OVERFLOW_BIT] = ovAdd;
         end
         OP_SUBB: begin
            statusStore_nxt[CARRY_BIT]    = sum9[8];
            statusStore_nxt[NIBBLE_BIT]   = sum5[4];
            statusStore_nxt[OVERFLOW_BIT] = ovSub;
         end
         OP_MUL: begin
            statusStore_nxt[CARRY_BIT]    = 1'b0;
            statusStore_nxt[OVERFLOW_BIT] = (mulHigh != 8'h00);
            second_nxt                    = mulHigh;
         end
         OP_DIV: begin
            statusStore_nxt[CARRY_BIT]    = 1'b0;
            statusStore_nxt[OVERFLOW_BIT] = (arithReq.opB == 8'h00);
            if (arithReq.opB != 8'h00) begin
               second_nxt = divRem;
            end
         end
         default: begin
         end
      endcase
      statusStore_nxt[PARITY_BIT] = 1'b0;
   end

   // Read path: registered data for the addressed register
   always_comb begin
      if (hit(sfrReq.addr, STATUS_WORD_ADDR)) begin
         rdData_nxt = {statusStore_nxt[7:1], parity};
      end else if (hit(sfrReq.addr, SECOND_OPND_ADDR)) begin
         rdData_nxt = second_nxt;
      end else begin
         rdData_nxt = 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         statusStore_r <= STATUS_WORD_RESET;
         second_r      <= SECOND_OPND_RESET;
      end else begin
         statusStore_r <= statusStore_nxt;
         second_r      <= second_nxt;
      end
   end

   // Read data register
   always_ff @(posedge clock) begin
      if (rst) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   assign statusWord    = {statusStore_r[7:1], parity};
   assign secondOperand = second_r;
   assign rdData        = rdData_r;
   assign carryOut      = statusStore_r[CARRY_BIT];
   assign bankBase      = {statusStore_r[BANK_HI_BIT:BANK_LO_BIT], 3'b000};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_parity;
      @(posedge clock) disable iff (rst) statusWord[PARITY_BIT] == ^accValue;
   endproperty
   a_parity: assert property (p_parity) else $error("parity flag wrong");

   property p_reset;
      @(posedge clock) rst |=> (statusWord[7:1] == 7'h00 && secondOperand == 8'h00
                                && rdData == 8'h00 && bankBase == 5'h00);
   endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong");

   property p_bank;
      @(posedge clock) disable iff (rst)
         bankBase == {statusWord[BANK_HI_BIT:BANK_LO_BIT], 3'b000};
   endproperty
   a_bank: assert property (p_bank) else $error("bank base wrong");

   property p_user_hold;
      @(posedge clock) disable iff (rst)
         !(hit(sfrReq.addr, STATUS_WORD_ADDR) && (sfrReq.byteWr || sfrReq.bitWr))
         |=> $stable(statusWord[USER0_BIT]) && $stable(statusWord[USER1_BIT]);
   endproperty
   a_user_hold: assert property (p_user_hold) else $error("user flag changed");

   property p_add_carry;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_ADD
         |=> statusWord[CARRY_BIT]
             == ({1'b0, $past(arithReq.opA)} + {1'b0, $past(arithReq.opB)} > 9'h0FF);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

   property p_mul_ov;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_MUL
         |=> statusWord[OVERFLOW_BIT] == ({$past(mulHigh), $past(mulLow)} > 16'h00FF);
   endproperty
   a_mul_ov: assert property (p_mul_ov) else $error("multiply overflow wrong");

   property p_div_ov;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_DIV |=> statusWord[OVERFLOW_BIT] == ($past(arithReq.opB) == 8'h00);
   endproperty
   a_div_ov: assert property (p_div_ov) else $error("divide overflow wrong");

   property p_add_ov;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_ADD && arithReq.opA == 8'h7F && arithReq.opB == 8'h01
         |=> statusWord[OVERFLOW_BIT] && !statusWord[CARRY_BIT];
   endproperty
   a_add_ov: assert property (p_add_ov) else $error("add overflow wrong");

   property p_nibble;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_ADD && arithReq.opA == 8'h0F && arithReq.opB == 8'h01
         |=> statusWord[NIBBLE_BIT] && !statusWord[OVERFLOW_BIT];
   endproperty
   a_nibble: assert property (p_nibble) else $error("nibble carry wrong");

   property p_second_wr;
      @(posedge clock) disable iff (rst)
         sfrReq.byteWr && sfrReq.addr == SECOND_OPND_ADDR && arithReq.op == OP_NONE
         |=> secondOperand == $past(sfrReq.wrData);
   endproperty
   a_second_wr: assert property (p_second_wr) else $error("second operand write lost");

   // ----------------------------------------------------------------
   // Checks: register access and read path
   // ----------------------------------------------------------------
   property p_rd_second;
      @(posedge clock) disable iff (rst)
         hit(sfrReq.addr, SECOND_OPND_ADDR) && !sfrReq.byteWr && !sfrReq.bitWr
         && arithReq.op == OP_NONE |=> rdData == $past(secondOperand);
   endproperty
   a_rd_second: assert property (p_rd_second) else $error("second operand read wrong");

   property p_rd_parity;
      @(posedge clock) disable iff (rst)
         hit(sfrReq.addr, STATUS_WORD_ADDR) |=> rdData[PARITY_BIT] == ^$past(accValue);
   endproperty
   a_rd_parity: assert property (p_rd_parity) else $error("read parity wrong");

   property p_user_wr;
      @(posedge clock) disable iff (rst)
         sfrReq.bitWr && hit(sfrReq.addr, STATUS_WORD_ADDR) && sfrReq.bitSel == 3'(USER0_BIT)
         |=> statusWord[USER0_BIT] == $past(sfrReq.bitVal);
   endproperty
   a_user_wr: assert property (p_user_wr) else $error("user flag write lost");

   property p_bank_wr;
      @(posedge clock) disable iff (rst)
         sfrReq.byteWr && !sfrReq.bitWr && hit(sfrReq.addr, STATUS_WORD_ADDR)
         |=> bankBase[4:3] == $past(sfrReq.wrData[BANK_HI_BIT:BANK_LO_BIT])
             && bankBase[2:0] == 3'b000;
   endproperty
   a_bank_wr: assert property (p_bank_wr) else $error("bank select write wrong");

   // ----------------------------------------------------------------
   // Checks: arithmetic flags and second operand results
   // ----------------------------------------------------------------
   property p_addc_carry;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_ADDC
         |=> carryOut == ({1'b0, $past(arithReq.opA)} + {1'b0, $past(arithReq.opB)}
                          + {8'h00, $past(carryOut)} > 9'h0FF);
   endproperty
   a_addc_carry: assert property (p_addc_carry) else $error("add with carry wrong");

   property p_sub_borrow;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_SUBB
         |=> carryOut == ({1'b0, $past(arithReq.opA)}
                          < {1'b0, $past(arithReq.opB)} + {8'h00, $past(carryOut)});
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong");

   property p_sub_ov;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_SUBB && arithReq.opA == 8'h80 && arithReq.opB == 8'h01
         |=> statusWord[OVERFLOW_BIT] && !carryOut;
   endproperty
   a_sub_ov: assert property (p_sub_ov) else $error("subtract overflow wrong");

   property p_add_clear;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_ADD && arithReq.opA[7] != arithReq.opB[7]
         |=> !statusWord[OVERFLOW_BIT];
   endproperty
   a_add_clear: assert property (p_add_clear) else $error("overflow not cleared");

   property p_mul_second;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_MUL |=> secondOperand == $past(mulHigh);
   endproperty
   a_mul_second: assert property (p_mul_second) else $error("product high byte lost");

   property p_div_second;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_DIV && arithReq.opB != 8'h00 |=> secondOperand == $past(divRem);
   endproperty
   a_div_second: assert property (p_div_second) else $error("remainder lost");

   property p_div_keep;
      @(posedge clock) disable iff (rst)
         arithReq.op == OP_DIV && arithReq.opB == 8'h00 && !sfrReq.byteWr && !sfrReq.bitWr
         |=> $stable(secondOperand);
   endproperty
   a_div_keep: assert property (p_div_keep) else $error("zero divide changed operand");

endmodule // cpu_status_and_b_register

// ### test/core_alu_model.sv
// Purpose: Behavioural multiply and divide results of the core
// Assumes: Results are valid in the same cycle as the request
// Notes:   Divide by zero returns the inverted operands as filler, never a stale value
`timescale 1ns/10ps
module core_alu_model
   import cpu_status_pkg::*;
(
   input  wire arith_req_s arithReq,
   output logic      [7:0] mulHigh,
   output logic      [7:0] mulLow,
   output logic      [7:0] divQuot,
   output logic      [7:0] divRem
);
   logic [15:0] product;
   always_comb begin
      product = arithReq.opA * arithReq.opB;
      mulHigh = product[15:8];
      mulLow  = product[7:0];
      divQuot = (arithReq.opB != 8'h00) ? arithReq.opA / arithReq.opB : ~arithReq.opA;
      divRem  = (arithReq.opB != 8'h00) ? arithReq.opA % arithReq.opB : ~arithReq.opB;
   end
endmodule // core_alu_model

// ### test/testbench.sv
// Purpose: Self-checking bench for the status word and second operand registers
// Assumes: At most one operation and one register access per cycle
// Notes:   Inputs change at the falling edge, results checked one cycle later
`timescale 1ns/10ps
module testbench;
   import cpu_status_pkg::*;
   logic       clock, rst, carryOut;
   sfr_req_s   sfrReq;
   arith_req_s arithReq;
   logic [7:0] accValue, mulHigh, mulLow, divQuot, divRem, statusWord, secondOperand, rdData;
   logic [7:0] expPsw, expB, expRd;
   logic [4:0] bankBase;
   logic       rdCheck;
   int         failures, checks_done, seed, kind;

   cpu_status_and_b_register dut (.clock(clock), .rst(rst), .sfrReq(sfrReq),
      .arithReq(arithReq), .accValue(accValue), .mulHigh(mulHigh), .mulLow(mulLow),
      .divQuot(divQuot), .divRem(divRem), .statusWord(statusWord),
      .secondOperand(secondOperand), .rdData(rdData), .carryOut(carryOut),
      .bankBase(bankBase));
   core_alu_model alu (.arithReq(arithReq), .mulHigh(mulHigh), .mulLow(mulLow),
      .divQuot(divQuot), .divRem(divRem));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // Expected flags and second operand after one operation
   // ----------------------------------------------------------------
   function automatic logic [15:0] arith(arith_req_s r, logic [7:0] p, logic [7:0] b);
      logic [8:0]  s;
      logic [4:0]  n;
      logic [15:0] m;
      logic        c;
      c = (r.op == OP_ADD) ? 1'b0 : p[7];
      case (r.op)
         OP_ADD, OP_ADDC: begin
            s = {1'b0, r.opA} + {1'b0, r.opB} + {8'h00, c};
            n = {1'b0, r.opA[3:0]} + {1'b0, r.opB[3:0]} + {4'h0, c};
            p[7] = s[8];
            p[6] = n[4];
            p[2] = (r.opA[7] == r.opB[7]) && (s[7] != r.opA[7]);
         end
         OP_SUBB: begin
            s = {1'b0, r.opA} - r.opB - c;
            n = {1'b0, r.opA[3:0]} - r.opB[3:0] - c;
            p[7] = s[8];
            p[6] = n[4];
            p[2] = (r.opA[7] != r.opB[7]) && (s[7] != r.opA[7]);
         end
         OP_MUL: begin
            m = r.opA * r.opB;
            p[7] = 1'b0;
            p[2] = |m[15:8];
            b = m[15:8];
         end
         OP_DIV: begin
            p[7] = 1'b0;
            p[2] = (r.opB == 8'h00);
            if (r.opB != 8'h00) b = r.opA % r.opB;
         end
         default: ;
      endcase
      return {p, b};
   endfunction

   // Base of R0 for each bank select value
   function automatic logic [7:0] bank_base(input logic [1:0] bs);
      case (bs)
         2'b00:   return 8'h00;
         2'b01:   return 8'h08;
         2'b10:   return 8'h10;
         default: return 8'h18;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic step(input arith_req_s a, input sfr_req_s q);
      logic [7:0] p;
      logic [7:0] b;
      p = expPsw;
      b = expB;
      arithReq = a;
      sfrReq = q;
      accValue = 8'($random(seed));
      if (q.byteWr && q.addr == STATUS_WORD_ADDR) p = q.wrData;
      if (q.byteWr && q.addr == SECOND_OPND_ADDR) b = q.wrData;
      if (q.bitWr && q.addr == STATUS_WORD_ADDR) p[q.bitSel] = q.bitVal;
      if (q.bitWr && q.addr == SECOND_OPND_ADDR) b[q.bitSel] = q.bitVal;
      {expPsw, expB} = arith(a, p, b);
      expRd = (q.addr == STATUS_WORD_ADDR) ? {expPsw[7:1], ^accValue}
              : (q.addr == SECOND_OPND_ADDR) ? expB : 8'h00;
      rdCheck = (a.op == OP_NONE);
      @(negedge clock);
      chk("status", {expPsw[7:1], ^accValue}, statusWord);
      chk("second", expB, secondOperand);
      chk("carry", {7'h00, expPsw[7]}, {7'h00, carryOut});
      chk("bank", bank_base(expPsw[4:3]), {3'h0, bankBase});
      if (rdCheck) chk("read", expRd, rdData);
   endtask

   task automatic op(input arith_op_e o, input logic [7:0] a, input logic [7:0] b);
      step('{o, a, b}, '0);
   endtask

   task automatic wr(input logic bw, input logic [7:0] ad, input logic [2:0] bs,
                     input logic [7:0] d);
      step('{OP_NONE, 8'h00, 8'h00}, '{~bw, bw, ad, bs, d, d[0]});
   endtask

   task automatic rd(input logic [7:0] ad);
      step('{OP_NONE, 8'h00, 8'h00}, '{1'b0, 1'b0, ad, 3'h0, 8'h00, 1'b0});
   endtask

   task results;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #50000;
      failures++;
      results();
   end

   initial begin
      seed = 32'h24e53613;
      rst = 1'b1;
      sfrReq = '0;
      arithReq = '0;
      accValue = 8'h00;
      expPsw = 8'h00;
      expB = 8'h00;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      chk("rststatus", {7'h00, ^accValue}, statusWord);
      chk("rstsecond", 8'h00, secondOperand);
      op(OP_ADD, 8'h7F, 8'h01);
      op(OP_ADD, 8'hFF, 8'h01);
      op(OP_ADDC, 8'h00, 8'h00);
      op(OP_SUBB, 8'h00, 8'h01);
      op(OP_SUBB, 8'h80, 8'h01);
      op(OP_MUL, 8'h10, 8'h10);
      op(OP_MUL, 8'h0F, 8'h11);
      op(OP_DIV, 8'h20, 8'h00);
      op(OP_DIV, 8'h20, 8'h07);
      op(OP_ADD, 8'h0F, 8'h01);
      step('{OP_ADD, 8'hFF, 8'h01}, '{1'b1, 1'b0, STATUS_WORD_ADDR, 3'h0, 8'h3E, 1'b0});
      for (int i = 0; i < 4; i++) wr(1'b0, STATUS_WORD_ADDR, 3'h0, {3'b111, 2'(i), 3'b111});
      wr(1'b1, STATUS_WORD_ADDR, 3'h0, 8'h01);
      wr(1'b0, 8'hE0, 3'h0, 8'hFF);
      rd(STATUS_WORD_ADDR);
      rd(SECOND_OPND_ADDR);
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      expPsw = 8'h00;
      expB = 8'h00;
      chk("rststatus", {7'h00, ^accValue}, statusWord);
      chk("rstsecond", 8'h00, secondOperand);
      for (int i = 0; i < 400; i++) begin
         kind = {$random(seed)} % 4;
         if (kind == 0) op(arith_op_e'(3'(1 + {$random(seed)} % 5)), 8'($random(seed)),
                           8'($random(seed)));
         else if (kind == 3) rd(($random(seed) & 1) ? STATUS_WORD_ADDR
                                : SECOND_OPND_ADDR);
         else wr(kind[0], ({$random(seed)} % 3 == 0) ? 8'($random(seed)) :
                 ($random(seed) & 1) ? STATUS_WORD_ADDR : SECOND_OPND_ADDR,
                 3'($random(seed)), 8'($random(seed)));
      end
      results();
   end
endmodule // testbench
